// file: hdl/msr_byte_shift.sv
// Purpose: holding register that hands out a sample byte by byte
// Assumes: value left-justified, most significant byte first
// Notes: output byte comes straight from the holding register
`timescale 1ns/1ns

module msr_byte_shift
  import msr_pkg::*;
#(
  parameter int WIDTH = 32
)
(
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic ce_in,
  // control
  input wire logic load_in,
  input wire logic shift_in,
  input wire logic [WIDTH-1:0] value_in,
  // byte out
  output logic [7:0] byte_out
);

  logic [WIDTH-1:0] hold;

  // ----------------------------------------
  // holding register
  // ----------------------------------------
  // one sample per report
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
      hold <= '0;
    else if (ce_in && load_in)
      hold <= value_in;
    else if (ce_in && shift_in)
      hold <= {hold[WIDTH-9:0], 8'h00};
  end

  assign byte_out = hold[WIDTH-1 -: 8];

  property p_msb_next;
    @(posedge clk_in) disable iff (sys_rst_in)
    (ce_in && shift_in && !load_in) |=>
      (byte_out == $past(hold[WIDTH-9 -: 8]));
  endproperty
  a_msb_next: assert property (p_msb_next)
    else $error("byte order broken");

endmodule

// file: hdl/msr_pkg.sv
// Purpose: shared constants of the motion status readback block
// Assumes: 8-bit host port, 16-bit signals register
// Notes: command codes not fixed elsewhere are plain defaults

package msr_pkg;

  // ----------------------------------------
  // command codes
  // ----------------------------------------
  localparam logic [7:0] MSR_CMD_START = 8'h01;
  localparam logic [7:0] MSR_CMD_RD_DES_VEL = 8'h07;
  localparam logic [7:0] MSR_CMD_RD_DES_POS = 8'h08;
  localparam logic [7:0] MSR_CMD_RD_INDEX = 8'h09;
  localparam logic [7:0] MSR_CMD_RD_ACT_POS = 8'h0a;
  localparam logic [7:0] MSR_CMD_RD_ACT_VEL = 8'h0b;
  localparam logic [7:0] MSR_CMD_RD_SIGNALS = 8'h0c;
  localparam logic [7:0] MSR_CMD_RD_SUM = 8'h0d;
  // codes below are plain defaults
  localparam logic [7:0] MSR_CMD_SET_INDEX = 8'h03;
  localparam logic [7:0] MSR_CMD_NARROW_OUT = 8'h05;
  localparam logic [7:0] MSR_CMD_WIDE_OUT = 8'h06;
  localparam logic [7:0] MSR_CMD_UPDATE_FILT = 8'h04;
  localparam logic [7:0] MSR_CMD_ERR_STOP = 8'h1a;
  localparam logic [7:0] MSR_CMD_ERR_INT = 8'h1b;
  localparam logic [7:0] MSR_CMD_RESET_INT = 8'h1d;

  // ----------------------------------------
  // signals register layout
  // ----------------------------------------
  localparam int MSR_BIT_HOST_INT = 15;
  localparam int MSR_BIT_ACCEL = 14;
  localparam int MSR_BIT_FILT_PEND = 13;
  localparam int MSR_BIT_FWD = 12;
  localparam int MSR_BIT_VEL_MODE = 11;
  localparam int MSR_BIT_ON_TARGET = 10;
  localparam int MSR_BIT_ERR_STOP = 9;
  localparam int MSR_BIT_NARROW = 8;
  localparam int MSR_BIT_MOTOR_OFF = 7;
  localparam int MSR_BIT_ACQ_INDEX = 0;
  localparam int MSR_NUM_INT = 6;
  localparam logic NARROW_RST = 1'b1;

  // ----------------------------------------
  // report lengths in bytes
  // ----------------------------------------
  localparam logic [2:0] MSR_LEN_LONG = 3'h4;
  localparam logic [2:0] MSR_LEN_SHORT = 3'h2;
  localparam logic [2:0] MSR_LEN_ONE = 3'h1;

  // ----------------------------------------
  // readback sequencer states
  // ----------------------------------------
  typedef enum logic [1:0]
  {
    MSR_IDLE = 2'b01,
    MSR_SEND = 2'b10
  } msr_state_t;

endpackage

// file: hdl/msr_readback.sv
// Purpose: signals register and data report port of a motion controller
// Assumes: host strobes synchronous to clk_in, active low
// Notes: strobe falling edges mark accesses; data reads hand out bytes
`timescale 1ns/1ns

// How it works
// - unmasked events raise host interrupt and bit 15; reset command clears
// - acceleration load sets bit 14; start motion clears it
// - update filter sets bit 13; end of sample interval clears it
// - direction from trajectory load, applied to bit 12 at start motion
// - velocity mode from trajectory load, applied to bit 11 at start
// - trajectory done sets bit 10; next start motion clears it
// - error stop command sets bit 9; error interrupt command clears it
// - reset and narrow output set bit 8; wide output clears it
// - low byte mirrors status; bit 0 armed by index capture until pulse
// - index position read returns four bytes
// - desired position read returns four bytes
// - actual position read returns four bytes
// - desired velocity read gives four signed bytes, integer then fraction
// - actual velocity read returns two signed integer bytes
// - integral sum read returns two bytes
// - multi-byte reports go most significant byte first
// - a new command abandons an unfinished report
// - status interrupt bits update whatever the mask
// - writes while busy ignored; busy data reads give stale data, no error
// - chip select, port select and read low return status byte
// - signals read returns two bytes, upper first
module msr_readback
  import msr_pkg::*;
(
  // clock, enable, reset
  input wire logic clk_in,
  input wire logic ce_in,
  input wire logic sys_rst_in,
  // host port
  input wire logic cs_n_in,
  input wire logic port_select_in,
  input wire logic rd_n_in,
  input wire logic wr_n_in,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_out,
  output logic host_int_out,
  // core status and events
  input wire logic busy_in,
  input wire logic motor_off_in,
  input wire logic [MSR_NUM_INT-1:0] int_enable_in,
  input wire logic breakpoint_evt_in,
  input wire logic pos_err_evt_in,
  input wire logic wrap_evt_in,
  input wire logic index_pulse_in,
  input wire logic traj_done_in,
  input wire logic sample_tick_in,
  // trajectory and acceleration loads
  input wire logic accel_load_in,
  input wire logic traj_load_in,
  input wire logic traj_forward_in,
  input wire logic traj_velocity_in,
  // report sources
  input wire logic [31:0] index_pos_in,
  input wire logic [31:0] desired_pos_in,
  input wire logic [31:0] actual_pos_in,
  input wire logic [31:0] desired_vel_in,
  input wire logic [15:0] actual_vel_in,
  input wire logic [15:0] integ_sum_in,
  // register view
  output logic [15:0] signal_flags_out
);

  logic wr_prev;
  logic rd_prev;
  logic wr_fall;
  logic rd_fall;
  logic cmd_take;
  logic dwr_take;
  logic stat_rd;
  logic drd_take;
  logic do_start;
  logic do_reset_int;
  logic do_filt;
  logic do_err_stop;
  logic do_err_int;
  logic do_narrow;
  logic do_wide;
  logic do_arm;
  logic rpt_load;
  logic [2:0] rpt_len;
  logic [31:0] rpt_value;
  logic cmd_err_evt;
  logic index_hit;
  logic [MSR_NUM_INT-1:0] int_evt;
  logic [MSR_NUM_INT-1:0] int_flags;
  logic [7:0] rpt_byte;
  msr_state_t state;
  logic [2:0] bytes_left;
  logic accel_flag;
  logic filt_flag;
  logic fwd_flag;
  logic vel_flag;
  logic fwd_pend;
  logic vel_pend;
  logic on_target;
  logic err_stop;
  logic narrow;
  logic motor_off;
  logic acq_index;

  // ----------------------------------------
  // host strobe decode
  // ----------------------------------------
  // edge detect so a long strobe counts as one access
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      wr_prev <= 1'b1;
      rd_prev <= 1'b1;
    end
    else if (ce_in)
    begin
      wr_prev <= wr_n_in;
      rd_prev <= rd_n_in;
    end
  end

  assign wr_fall = wr_prev && !wr_n_in && !cs_n_in;
  assign rd_fall = rd_prev && !rd_n_in && !cs_n_in;
  assign cmd_take = wr_fall && !port_select_in && !busy_in;
  assign dwr_take = wr_fall && port_select_in && !busy_in;
  assign stat_rd = rd_fall && !port_select_in;
  assign drd_take = rd_fall && port_select_in && !busy_in;

  // command execution pulses
  assign do_start = cmd_take && (data_in == MSR_CMD_START);
  assign do_reset_int = cmd_take && (data_in == MSR_CMD_RESET_INT);
  assign do_filt = cmd_take && (data_in == MSR_CMD_UPDATE_FILT);
  assign do_err_stop = cmd_take && (data_in == MSR_CMD_ERR_STOP);
  assign do_err_int = cmd_take && (data_in == MSR_CMD_ERR_INT);
  assign do_narrow = cmd_take && (data_in == MSR_CMD_NARROW_OUT);
  assign do_wide = cmd_take && (data_in == MSR_CMD_WIDE_OUT);
  assign do_arm = cmd_take && (data_in == MSR_CMD_SET_INDEX);

  // ----------------------------------------
  // report selection
  // ----------------------------------------
  // short values are left-justified so the shifter serves all
  always_comb
  begin
    rpt_load = cmd_take;
    rpt_len = MSR_LEN_LONG;
    rpt_value = '0;
    unique case (data_in)
      MSR_CMD_RD_INDEX: rpt_value = index_pos_in;
      MSR_CMD_RD_DES_POS: rpt_value = desired_pos_in;
      MSR_CMD_RD_ACT_POS: rpt_value = actual_pos_in;
      MSR_CMD_RD_DES_VEL: rpt_value = desired_vel_in;
      MSR_CMD_RD_ACT_VEL:
      begin
        rpt_value = {actual_vel_in, 16'h0000};
        rpt_len = MSR_LEN_SHORT;
      end
      MSR_CMD_RD_SUM:
      begin
        rpt_value = {integ_sum_in, 16'h0000};
        rpt_len = MSR_LEN_SHORT;
      end
      MSR_CMD_RD_SIGNALS:
      begin
        rpt_value = {signal_flags_out, 16'h0000};
        rpt_len = MSR_LEN_SHORT;
      end
      default:
      begin
        rpt_load = 1'b0;
        rpt_len = MSR_LEN_ONE;
      end
    endcase
  end

  msr_byte_shift #(.WIDTH(32)) u_shift (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .ce_in(ce_in),
    .load_in(rpt_load),
    .shift_in(drd_take && (state == MSR_SEND)),
    .value_in(rpt_value),
    .byte_out(rpt_byte)
  );

  // ----------------------------------------
  // readback sequencer
  // ----------------------------------------
  // new command restarts
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      state <= MSR_IDLE;
      bytes_left <= '0;
    end
    else if (ce_in)
    begin
      if (cmd_take)
      begin
        state <= rpt_load ? MSR_SEND : MSR_IDLE;
        bytes_left <= rpt_load ? rpt_len : '0;
      end
      else if (drd_take && state == MSR_SEND)
      begin
        bytes_left <= bytes_left - MSR_LEN_ONE;
        if (bytes_left == MSR_LEN_ONE)
          state <= MSR_IDLE;
      end
    end
  end

  // a read with no report pending, or a write mid-report, is an error
  assign cmd_err_evt = (drd_take && state == MSR_IDLE)
    || (dwr_take && state == MSR_SEND);

  // ----------------------------------------
  // host data port
  // ----------------------------------------
  // busy data reads leave the old byte: stale buffer contents
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      data_out <= '0;
      data_oe_out <= 1'b0;
    end
    else if (ce_in)
    begin
      data_oe_out <= !cs_n_in && !rd_n_in;
      if (stat_rd)
        data_out <= {signal_flags_out[7:1], busy_in};
      else if (drd_take && state == MSR_SEND)
        data_out <= rpt_byte;
    end
  end

  // ----------------------------------------
  // interrupt flags, bits 6 to 1
  // ----------------------------------------
  assign index_hit = index_pulse_in && acq_index;
  assign int_evt = {breakpoint_evt_in, pos_err_evt_in, wrap_evt_in,
                    index_hit, traj_done_in, cmd_err_evt};

  generate
    for (genvar i = 0; i < MSR_NUM_INT; i++)
    begin : g_int
      always_ff @(posedge clk_in)
      begin
        if (sys_rst_in)
          int_flags[i] <= 1'b0;
        else if (ce_in && int_evt[i])
          int_flags[i] <= 1'b1;
        else if (ce_in && do_reset_int)
          int_flags[i] <= 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
      host_int_out <= 1'b0;
    else if (ce_in && |(int_evt & int_enable_in))
      host_int_out <= 1'b1;
    else if (ce_in && do_reset_int)
      host_int_out <= 1'b0;
  end

  // ----------------------------------------
  // signals register bits 14 to 7 and bit 0
  // ----------------------------------------
  // sets win over a clear in the same cycle
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      accel_flag <= 1'b0;
      filt_flag <= 1'b0;
      on_target <= 1'b0;
    end
    else if (ce_in)
    begin
      if (accel_load_in)
        accel_flag <= 1'b1;
      else if (do_start)
        accel_flag <= 1'b0;
      if (do_filt)
        filt_flag <= 1'b1;
      else if (sample_tick_in)
        filt_flag <= 1'b0;
      if (traj_done_in)
        on_target <= 1'b1;
      else if (do_start)
        on_target <= 1'b0;
    end
  end

  // mode and direction wait in pending copies until start
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      fwd_pend <= 1'b0;
      vel_pend <= 1'b0;
      fwd_flag <= 1'b0;
      vel_flag <= 1'b0;
    end
    else if (ce_in)
    begin
      if (traj_load_in)
      begin
        fwd_pend <= traj_forward_in;
        vel_pend <= traj_velocity_in;
      end
      if (do_start)
      begin
        fwd_flag <= fwd_pend;
        vel_flag <= vel_pend;
      end
    end
  end

  // output width, error stop, index arm, motor off mirror
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      err_stop <= 1'b0;
      narrow <= NARROW_RST;
      acq_index <= 1'b0;
      motor_off <= 1'b0;
    end
    else if (ce_in)
    begin
      motor_off <= motor_off_in;
      if (do_err_stop)
        err_stop <= 1'b1;
      else if (do_err_int)
        err_stop <= 1'b0;
      if (do_narrow)
        narrow <= 1'b1;
      else if (do_wide)
        narrow <= 1'b0;
      if (do_arm)
        acq_index <= 1'b1;
      else if (index_pulse_in)
        acq_index <= 1'b0;
    end
  end

  assign signal_flags_out = {host_int_out, accel_flag, filt_flag, fwd_flag,
                             vel_flag, on_target, err_stop, narrow,
                             motor_off, int_flags, acq_index};

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_int_raise;
    @(posedge clk_in) disable iff (sys_rst_in)
    (ce_in && |(int_evt & int_enable_in)) |=>
      host_int_out && signal_flags_out[MSR_BIT_HOST_INT];
  endproperty
  a_int_raise: assert property (p_int_raise)
    else $error("host interrupt not raised");

  property p_accel;
    @(posedge clk_in) disable iff (sys_rst_in)
    (ce_in && do_start && !accel_load_in) |=>
      !signal_flags_out[MSR_BIT_ACCEL];
  endproperty
  a_accel: assert property (p_accel)
    else $error("accel flag not cleared by start");

  property p_filt;
    @(posedge clk_in) disable iff (sys_rst_in)
    (ce_in && sample_tick_in && !do_filt) |=>
      !signal_flags_out[MSR_BIT_FILT_PEND];
  endproperty
  a_filt: assert property (p_filt)
    else $error("filter flag outlived interval");

  property p_mode;
    @(posedge clk_in) disable iff (sys_rst_in)
    (ce_in && traj_load_in && !do_start) |=>
      $stable(signal_flags_out[MSR_BIT_VEL_MODE])
      && $stable(signal_flags_out[MSR_BIT_FWD]);
  endproperty
  a_mode: assert property (p_mode)
    else $error("mode changed before start");

  property p_narrow;
    @(posedge clk_in) disable iff (sys_rst_in)
    (ce_in && do_wide) |=> !signal_flags_out[MSR_BIT_NARROW];
  endproperty
  a_narrow: assert property (p_narrow)
    else $error("wide output not taken");

  property p_report;
    @(posedge clk_in) disable iff (sys_rst_in)
    (ce_in && cmd_take && data_in == MSR_CMD_RD_INDEX) |=>
      (state == MSR_SEND) && (bytes_left == MSR_LEN_LONG);
  endproperty
  a_report: assert property (p_report)
    else $error("index report not started");

  property p_busy;
    @(posedge clk_in) disable iff (sys_rst_in)
    (ce_in && busy_in && !stat_rd) |=> $stable(data_out)
      && $stable(state) && !$rose(int_flags[0]);
  endproperty
  a_busy: assert property (p_busy)
    else $error("busy access had an effect");

  property p_status;
    @(posedge clk_in) disable iff (sys_rst_in)
    (ce_in && stat_rd) |=> data_oe_out
      && data_out == {$past(signal_flags_out[7:1]), $past(busy_in)};
  endproperty
  a_status: assert property (p_status)
    else $error("status byte wrong");

  property p_arm;
    @(posedge clk_in) disable iff (sys_rst_in)
    (ce_in && do_arm) |=> signal_flags_out[MSR_BIT_ACQ_INDEX];
  endproperty
  a_arm: assert property (p_arm)
    else $error("index arm not set");

endmodule

// file: sim/msr_host_model.sv
// Purpose: behavioural host processor on the 8-bit command and data port
// Assumes: host changes its lines just after the falling edge of clk_in
// Notes: released write data shows the inverse of its last value
`timescale 1ns/1ns

module msr_host_model
(
  // clock
  input wire logic clk_in,
  // host port toward the device
  output logic cs_n_out,
  output logic port_select_out,
  output logic rd_n_out,
  output logic wr_n_out,
  output logic [7:0] data_out,
  input wire logic [7:0] data_in
);
  // ----------------------------------------
  // idle bus
  // ----------------------------------------
  // strobes idle high so the first falling strobe is a clean edge
  initial
  begin
    cs_n_out = 1'b1;
    port_select_out = 1'b0;
    rd_n_out = 1'b1;
    wr_n_out = 1'b1;
    data_out = 8'h5a;
  end

  // ----------------------------------------
  // bus cycles
  // ----------------------------------------
  // port from address bit zero, command before data
  // the model never polls and never splits a sequence
  task automatic write_byte(input logic port_sel, input logic [7:0] val);
    @(negedge clk_in);
    cs_n_out = 1'b0;
    port_select_out = port_sel;
    wr_n_out = 1'b0;
    data_out = val;
    @(negedge clk_in);
    cs_n_out = 1'b1;
    wr_n_out = 1'b1;
    // released data must not linger as a valid-looking value
    data_out = ~val;
    @(negedge clk_in);
  endtask

  // chip select, port zero and read low give the status byte
  task automatic read_byte(input logic port_sel, output logic [7:0] val);
    @(negedge clk_in);
    cs_n_out = 1'b0;
    port_select_out = port_sel;
    rd_n_out = 1'b0;
    @(negedge clk_in);
    val = data_in;
    cs_n_out = 1'b1;
    rd_n_out = 1'b1;
    // strobe must be seen high for one edge before the next access
    @(negedge clk_in);
  endtask
endmodule

// file: sim/tb.sv
// Purpose: self-checking bench of the motion status readback block
// Assumes: one 20 MHz clock, inputs changed at the falling edge
// Notes: report sources flip after each report command to prove early capture
`timescale 1ns/1ns

module tb;
  import msr_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  localparam int EV_ACCEL = 0, EV_LOAD = 1, EV_DONE = 2, EV_TICK = 3;
  localparam int EV_INDEX = 4, EV_WRAP = 5, EV_PERR = 6, EV_BRK = 7;
  localparam int TIMEOUT_CYC = 5000;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic cs_n, port_sel, rd_n, wr_n, data_oe, host_int;
  logic [7:0] wdata, rdata;
  logic busy = 1'b0;
  logic ce = 1'b1;
  logic motor_off = 1'b0;
  logic fwd = 1'b0;
  logic vel = 1'b0;
  logic [5:0] int_en = 6'h00;
  logic [7:0] evt = 8'h00;
  logic [31:0] idx_pos = 32'h8123_45a6;
  logic [31:0] des_pos = 32'h3f10_2c07;
  logic [31:0] act_pos = 32'hc001_77e9;
  logic [31:0] des_vel = 32'hfffe_8000;
  logic [15:0] act_vel = 16'hfffd;
  logic [15:0] isum = 16'h1b3c;
  logic [15:0] flags;
  int bad_count = 0;
  int n_tests = 0;
  int cycles = 0;

  // ----------------------------------------
  // device and host
  // ----------------------------------------
  msr_readback msr_readback_inst (.clk_in(clk_in), .ce_in(ce),
    .sys_rst_in(sys_rst_in), .cs_n_in(cs_n), .port_select_in(port_sel),
    .rd_n_in(rd_n), .wr_n_in(wr_n), .data_in(wdata), .data_out(rdata),
    .data_oe_out(data_oe), .host_int_out(host_int), .busy_in(busy),
    .motor_off_in(motor_off), .int_enable_in(int_en),
    .breakpoint_evt_in(evt[EV_BRK]), .pos_err_evt_in(evt[EV_PERR]),
    .wrap_evt_in(evt[EV_WRAP]), .index_pulse_in(evt[EV_INDEX]),
    .traj_done_in(evt[EV_DONE]), .sample_tick_in(evt[EV_TICK]),
    .accel_load_in(evt[EV_ACCEL]), .traj_load_in(evt[EV_LOAD]),
    .traj_forward_in(fwd), .traj_velocity_in(vel),
    .index_pos_in(idx_pos), .desired_pos_in(des_pos),
    .actual_pos_in(act_pos), .desired_vel_in(des_vel),
    .actual_vel_in(act_vel), .integ_sum_in(isum),
    .signal_flags_out(flags));

  msr_host_model msr_host_model_inst (.clk_in(clk_in), .cs_n_out(cs_n),
    .port_select_out(port_sel), .rd_n_out(rd_n), .wr_n_out(wr_n),
    .data_out(wdata), .data_in(rdata));

  // clock and hang guard
  always #25 clk_in = ~clk_in;

  always @(posedge clk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == TIMEOUT_CYC)
    begin
      bad_count++;
      give_verdict();
    end
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one-cycle event, then time for flags and interrupt to settle
  task automatic pulse(input int sel);
    evt[sel] = 1'b1;
    tick(1);
    evt = 8'h00;
    tick(2);
  endtask

  task automatic cmd(input logic [7:0] code);
    msr_host_model_inst.write_byte(1'b0, code);
    tick(1);
  endtask

  // inverting every source after the command shows a single early sample
  task automatic flip_sources();
    idx_pos = ~idx_pos;
    des_pos = ~des_pos;
    act_pos = ~act_pos;
    des_vel = ~des_vel;
    act_vel = ~act_vel;
    isum = ~isum;
  endtask

  task automatic read_report(input logic [7:0] code, input logic [31:0] exp,
                             input int n);
    logic [7:0] b;
    msr_host_model_inst.write_byte(1'b0, code);
    flip_sources();
    for (int i = 0; i < n; i++)
    begin
      msr_host_model_inst.read_byte(1'b1, b);
      check("byte", {24'h0, exp[8*(n-1-i) +: 8]}, {24'h0, b});
    end
    flip_sources();
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    check("flags after reset", 32'h0100, {16'h0, flags});
    check("oe after reset", 32'h0, {31'h0, data_oe});
    motor_off = 1'b1;
    tick(2);
    check("motor off mirror", 32'h1, {31'h0, flags[7]});
    motor_off = 1'b0;
    tick(2);
    $display("test reset done");
  endtask

  task automatic t_reports();
    read_report(MSR_CMD_RD_INDEX, 32'h8123_45a6, 4);
    read_report(MSR_CMD_RD_DES_POS, 32'h3f10_2c07, 4);
    read_report(MSR_CMD_RD_ACT_POS, 32'hc001_77e9, 4);
    read_report(MSR_CMD_RD_DES_VEL, 32'hfffe_8000, 4);
    read_report(MSR_CMD_RD_ACT_VEL, 32'h0000_fffd, 2);
    read_report(MSR_CMD_RD_SUM, 32'h0000_1b3c, 2);
    read_report(MSR_CMD_RD_SIGNALS, 32'h0000_0100, 2);
    $display("test reports done");
  endtask

  task automatic t_abort();
    logic [7:0] b;
    read_report(MSR_CMD_RD_INDEX, 32'h0000_8123, 2);
    read_report(MSR_CMD_RD_ACT_VEL, 32'h0000_fffd, 2);
    msr_host_model_inst.read_byte(1'b1, b);
    check("error after extra read", 32'h1, {31'h0, flags[1]});
    $display("test abort done");
  endtask

  task automatic t_busy();
    logic [7:0] b;
    cmd(MSR_CMD_RESET_INT);
    check("error cleared", 32'h0, {31'h0, flags[1]});
    busy = 1'b1;
    // ignored command: the data port still holds the last report byte
    cmd(MSR_CMD_RD_SIGNALS);
    msr_host_model_inst.read_byte(1'b1, b);
    check("stale busy read", 32'hfd, {24'h0, b});
    check("no error when busy", 32'h0, {31'h0, flags[1]});
    // drive enable is looked at while the read strobe is still low
    fork
      msr_host_model_inst.read_byte(1'b0, b);
      begin
        tick(2);
        check("drive enable", 32'h1, {31'h0, data_oe});
      end
    join
    check("status while busy", 32'h01, {24'h0, b});
    busy = 1'b0;
    msr_host_model_inst.read_byte(1'b1, b);
    check("busy write ignored", 32'h1, {31'h0, flags[1]});
    $display("test busy done");
  endtask

  task automatic t_motion();
    // with the enable low the event must leave no trace
    ce = 1'b0;
    pulse(EV_ACCEL);
    check("frozen accel", 32'h0, {31'h0, flags[14]});
    ce = 1'b1;
    pulse(EV_ACCEL);
    check("accel flag", 32'h1, {31'h0, flags[14]});
    fwd = 1'b1;
    vel = 1'b1;
    pulse(EV_LOAD);
    check("mode before start", 32'h0, {30'h0, flags[12:11]});
    cmd(MSR_CMD_START);
    check("mode at start", 32'h3, {30'h0, flags[12:11]});
    check("accel cleared", 32'h0, {31'h0, flags[14]});
    int_en = 6'h02;
    pulse(EV_DONE);
    check("on target", 32'h1, {31'h0, flags[10]});
    check("host int", 32'h1, {31'h0, host_int});
    check("int bits", 32'h8004, {16'h0, flags & 16'h8004});
    fwd = 1'b0;
    vel = 1'b0;
    pulse(EV_LOAD);
    check("mode held", 32'h3, {30'h0, flags[12:11]});
    cmd(MSR_CMD_START);
    check("start result", 32'h0, {29'h0, flags[12:10]});
    cmd(MSR_CMD_RESET_INT);
    check("int cleared", 32'h0, {16'h0, flags & 16'h8004});
    check("host int low", 32'h0, {31'h0, host_int});
    int_en = 6'h00;
    pulse(EV_WRAP);
    check("masked wrap", 32'h10, {24'h0, flags[7:0]});
    check("masked no int", 32'h0, {31'h0, host_int});
    int_en = 6'h30;
    pulse(EV_PERR);
    pulse(EV_BRK);
    check("enabled events", 32'h8070, {16'h0, flags & 16'h80ff});
    check("host int set", 32'h1, {31'h0, host_int});
    cmd(MSR_CMD_RESET_INT);
    int_en = 6'h00;
    $display("test motion done");
  endtask

  task automatic t_commands();
    cmd(MSR_CMD_UPDATE_FILT);
    check("filter flag", 32'h1, {31'h0, flags[13]});
    pulse(EV_TICK);
    check("filter cleared", 32'h0, {31'h0, flags[13]});
    cmd(MSR_CMD_ERR_STOP);
    check("stop flag", 32'h1, {31'h0, flags[9]});
    cmd(MSR_CMD_ERR_INT);
    check("stop cleared", 32'h0, {31'h0, flags[9]});
    cmd(MSR_CMD_WIDE_OUT);
    check("wide output", 32'h0, {31'h0, flags[8]});
    // reset in mid-run brings narrow output back
    sys_rst_in = 1'b1;
    tick(2);
    sys_rst_in = 1'b0;
    tick(1);
    check("flags after mid reset", 32'h0100, {16'h0, flags});
    cmd(MSR_CMD_NARROW_OUT);
    check("narrow output", 32'h1, {31'h0, flags[8]});
    cmd(MSR_CMD_SET_INDEX);
    check("index armed", 32'h1, {31'h0, flags[0]});
    pulse(EV_INDEX);
    check("index taken", 32'h08, {24'h0, flags[7:0]});
    read_report(MSR_CMD_RD_SIGNALS, 32'h0000_0108, 2);
    $display("test commands done");
  endtask

  // ----------------------------------------
  // verdict and main sequence
  // ----------------------------------------
  task automatic give_verdict();
    $display("Counts: %0d checks, %0d mismatches", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    repeat (4) @(posedge clk_in);
    @(negedge clk_in);
    sys_rst_in = 1'b0;
    tick(1);
    t_reset();
    t_reports();
    t_abort();
    t_busy();
    t_motion();
    t_commands();
    give_verdict();
  end
endmodule
